/* File: sos_pkg.sv */
package sos_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] SOS_PROGRESS_ADDR = 16'hFFA3;
  localparam logic [15:0] SOS_SELECT_ADDR = 16'hFFA4;
  localparam logic [7:0] SOS_PROGRESS_RST = 8'h00;
  localparam logic [2:0] SOS_SELECT_RST = 3'h5;

  // ----------------------------------------------------------------
  // Field layout and counts
  // ----------------------------------------------------------------
  localparam int SOS_SELECT_W = 3;
  localparam int SOS_STAGES = 5;
  localparam int SOS_CNT_W = 17;
  localparam int SOS_RING_W = 5;
  localparam logic [4:0] SOS_RING_WAIT_PERIODS = 5'h11;
  // Stabilization thresholds in main-clock periods
  localparam int unsigned SOS_THR_2P11 = 32'h0000_0800;
  localparam int unsigned SOS_THR_2P13 = 32'h0000_2000;
  localparam int unsigned SOS_THR_2P14 = 32'h0000_4000;
  localparam int unsigned SOS_THR_2P15 = 32'h0000_8000;
  localparam int unsigned SOS_THR_2P16 = 32'h0001_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SOS_RUN,
    SOS_HALT,
    SOS_STOP,
    SOS_MAIN_WAIT,
    SOS_RING_WAIT
  } sos_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } sos_reg_req_t;

  typedef struct packed {
    sos_mode_t mode;
    logic [SOS_CNT_W-1:0] cnt;
    logic cnt_run;
    logic [SOS_STAGES-1:0] done;
    logic [SOS_SELECT_W-1:0] sel;
    logic [SOS_RING_W-1:0] ring_cnt;
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic main_osc_en;
    logic internal_ring_oscillator_en;
    logic retain;
    logic osc_s1;
    logic osc_s2;
    logic ring_s1;
    logic ring_s2;
    logic ring_s3;
    logic mhalt_d;
    logic src_d;
  } sos_state_t;

endpackage : sos_pkg

/* File: sos_standby_ctrl.sv */
// Operation
// [RULE1] Halt gates the CPU clock; running oscillators keep running.
// [RULE2] Stop halts the main crystal oscillator.
// [RULE3] An interrupt releases stop; execution resumes after a stabilization wait.
// [RULE4] Halt and stop keep registers, memory and port latches unchanged.
// [RULE5] Stop from the ring clock stops main oscillator, ring keeps running.
// [RULE6] On ring clock the CPU stays stopped 17 ring periods after release.
// [RULE7] Software enters stop only from main or ring clock.
// [RULE8] Progress clears on reset, stop, main halt bit set, source bit set.
// [RULE9] Progress register is read-only, read as byte or bits.
// [RULE10] Progress bits set in order as thresholds pass, and stay set.
// [RULE11] Bits 4..0 mean 2^11,2^13,2^14,2^15,2^16 main periods; 7..5 zero.
// [RULE12] Counter counts only to the selected wait; later bits never set.
// [RULE13] Software selects a wait at least as long as the bit it polls.
// [RULE14] Wait counts from oscillation start, not from release.
// [RULE15] Software stops peripherals and the converter before standby.
// [RULE16] Progress stays readable while running from the ring clock.
// [RULE17] Ring halt bit acts only when the build option allows it.
// [RULE18] Select codes 1..5 pick 2^11..2^16 periods; reset loads 05H.
// [RULE19] Stop release on main clock holds CPU until selected count completes.
// [RULE20] A pending interrupt releases halt with no wait.
`timescale 1ns/10ps
module sos_standby_ctrl
  import sos_pkg::*;
#(
  parameter bit RING_STOPPABLE = 1'b0,
  parameter int unsigned THR_2P11 = SOS_THR_2P11,
  parameter int unsigned THR_2P13 = SOS_THR_2P13,
  parameter int unsigned THR_2P14 = SOS_THR_2P14,
  parameter int unsigned THR_2P15 = SOS_THR_2P15,
  parameter int unsigned THR_2P16 = SOS_THR_2P16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Standby instruction strobes and pending interrupt from the CPU core
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic irq_pending,
  // Clock generator control bits
  input wire logic main_osc_halt_bit,
  input wire logic cpu_clock_source_bit,
  input wire logic internal_ring_oscillator_halt_bit,
  // Oscillator status, asynchronous
  input wire logic main_osc_running,
  input wire logic ring_clock_tick,
  // Special function register access
  input wire sos_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Clock gating and oscillator enables
  output logic cpu_clk_en,
  output logic main_osc_en,
  output logic internal_ring_oscillator_en,
  output logic state_retain
);

  // ----------------------------------------------------------------
  // Threshold table
  // ----------------------------------------------------------------
  localparam logic [SOS_CNT_W-1:0] THR [SOS_STAGES] = '{
    THR_2P11[SOS_CNT_W-1:0],
    THR_2P13[SOS_CNT_W-1:0],
    THR_2P14[SOS_CNT_W-1:0],
    THR_2P15[SOS_CNT_W-1:0],
    THR_2P16[SOS_CNT_W-1:0]
  };

  sos_state_t st;
  sos_state_t next_st;
  logic [SOS_CNT_W-1:0] limit;
  logic [SOS_CNT_W-1:0] cnt_inc;
  logic osc_ok;
  logic ring_edge;
  logic prog_clear;
  logic counting;
  logic stop_on_ring;

  // ----------------------------------------------------------------
  // Selected wait
  // ----------------------------------------------------------------
  // Prohibited codes fall back to the longest wait, the safe side
  always_comb begin
    unique case (st.sel)
      3'h1: limit = THR[0]; // RULE18
      3'h2: limit = THR[1];
      3'h3: limit = THR[2];
      3'h4: limit = THR[3];
      default: limit = THR[4];
    endcase
  end

  // ----------------------------------------------------------------
  // Derived conditions
  // ----------------------------------------------------------------
  // Only the second oscillator synchroniser stage is looked at; the ring edge compares stages two and three
  assign osc_ok = st.osc_s2;
  assign ring_edge = st.ring_s2 & ~st.ring_s3;
  // Setting either bit is taken on its rising edge
  assign prog_clear = stop_exec | (main_osc_halt_bit & ~st.mhalt_d)
    | (cpu_clock_source_bit & ~st.src_d); // RULE8
  // Counting waits for the oscillator itself, not for the release
  assign counting = st.cnt_run & osc_ok & main_osc_en & ~main_osc_halt_bit; // RULE14
  assign cnt_inc = st.cnt + {{(SOS_CNT_W-1){1'b0}}, 1'b1};
  assign stop_on_ring = cpu_clock_source_bit;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Synchronisers for the oscillator side
    next_st.osc_s1 = main_osc_running;
    next_st.osc_s2 = st.osc_s1;
    next_st.ring_s1 = ring_clock_tick;
    next_st.ring_s2 = st.ring_s1;
    next_st.ring_s3 = st.ring_s2;
    next_st.mhalt_d = main_osc_halt_bit;
    next_st.src_d = cpu_clock_source_bit;

    // Stabilization counter and progress flags
    if (prog_clear) begin
      next_st.cnt = '0; // RULE8
      next_st.done = '0;
      next_st.cnt_run = 1'b0;
    end else if (counting) begin
      next_st.cnt = cnt_inc;
      // Stop at the selected wait so later flags stay clear
      if (cnt_inc >= limit) begin
        next_st.cnt_run = 1'b0; // RULE12
      end
      for (int i = 0; i < SOS_STAGES; i++) begin
        // Flags are sticky; each needs its own threshold and the selection
        if (cnt_inc >= THR[i] && THR[i] <= limit) begin
          next_st.done[i] = 1'b1; // RULE10 RULE11 RULE12
        end
      end
    end

    // Register access
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        // Byte or single-bit reads both come from this byte
        SOS_PROGRESS_ADDR: next_st.rdata = {3'h0, st.done[0], st.done[1],
          st.done[2], st.done[3], st.done[4]}; // RULE9 RULE11 RULE16
        SOS_SELECT_ADDR: next_st.rdata = {5'h00, st.sel};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Writes to the progress byte are dropped
    if (reg_req.wr && reg_req.addr == SOS_SELECT_ADDR) begin
      next_st.sel = reg_req.wdata[SOS_SELECT_W-1:0]; // RULE18 RULE9
    end

    // Ring oscillator honours its halt bit only when the build allows it
    next_st.internal_ring_oscillator_en = ~(RING_STOPPABLE & internal_ring_oscillator_halt_bit); // RULE17

    // Standby sequencer
    unique case (st.mode)
      SOS_RUN: begin
        next_st.cpu_clk_en = 1'b1;
        next_st.retain = 1'b0;
        next_st.main_osc_en = ~main_osc_halt_bit;
        if (stop_exec) begin
          // Main stops; ring state is left as it was
          next_st.mode = SOS_STOP; // RULE2 RULE5
          next_st.cpu_clk_en = 1'b0;
          next_st.main_osc_en = 1'b0; // RULE2 RULE5
          next_st.retain = 1'b1; // RULE4
        end else if (halt_exec) begin
          // Oscillator enables are not touched in halt
          next_st.mode = SOS_HALT; // RULE1
          next_st.cpu_clk_en = 1'b0; // RULE1
          next_st.retain = 1'b1; // RULE4
        end
      end
      SOS_HALT: begin
        next_st.main_osc_en = ~main_osc_halt_bit; // RULE1
        if (irq_pending) begin
          // No stabilization in halt: clock back at once
          next_st.mode = SOS_RUN; // RULE20
          next_st.cpu_clk_en = 1'b1;
          next_st.retain = 1'b0;
        end
      end
      SOS_STOP: begin
        next_st.main_osc_en = 1'b0;
        if (irq_pending) begin
          // Restart the oscillator and arm the counter from zero
          next_st.main_osc_en = ~main_osc_halt_bit; // RULE3
          next_st.cnt = '0;
          next_st.done = '0;
          next_st.cnt_run = 1'b1; // RULE3
          next_st.ring_cnt = '0;
          next_st.mode = stop_on_ring ? SOS_RING_WAIT : SOS_MAIN_WAIT;
        end
      end
      SOS_MAIN_WAIT: begin
        // CPU stays gated until the selected count has elapsed
        if (st.cnt >= limit) begin
          next_st.mode = SOS_RUN; // RULE19 RULE3
          next_st.cpu_clk_en = 1'b1;
          next_st.retain = 1'b0;
        end
      end
      SOS_RING_WAIT: begin
        // Main counter keeps running in the background meanwhile
        if (ring_edge) begin
          next_st.ring_cnt = st.ring_cnt + {{(SOS_RING_W-1){1'b0}}, 1'b1};
        end
        if (st.ring_cnt >= SOS_RING_WAIT_PERIODS) begin
          next_st.mode = SOS_RUN; // RULE6
          next_st.cpu_clk_en = 1'b1;
          next_st.retain = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Counter arms at reset so the first wait is timed as well
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st.mode <= SOS_RUN;
      st.cnt <= '0;
      st.cnt_run <= 1'b1;
      st.done <= '0; // RULE8
      st.sel <= SOS_SELECT_RST; // RULE18
      st.ring_cnt <= '0;
      st.rdata <= SOS_PROGRESS_RST;
      st.cpu_clk_en <= 1'b1;
      st.main_osc_en <= 1'b1;
      st.internal_ring_oscillator_en <= 1'b1;
      st.retain <= 1'b0;
      st.osc_s1 <= 1'b0;
      st.osc_s2 <= 1'b0;
      st.ring_s1 <= 1'b0;
      st.ring_s2 <= 1'b0;
      st.ring_s3 <= 1'b0;
      st.mhalt_d <= 1'b0;
      st.src_d <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign cpu_clk_en = st.cpu_clk_en;
  assign main_osc_en = st.main_osc_en;
  assign internal_ring_oscillator_en = st.internal_ring_oscillator_en;
  assign state_retain = st.retain;

endmodule : sos_standby_ctrl

/* File: sos_standby_ctrl_sva.sv */
`timescale 1ns/10ps
module sos_standby_ctrl_sva
  import sos_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Requests
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic irq_pending,
  input wire sos_reg_req_t reg_req,
  // Outputs watched
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_clk_en,
  input wire logic main_osc_en,
  input wire logic internal_ring_oscillator_en,
  input wire logic state_retain
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic run;
  logic halted;
  // Running state as seen at the ports
  assign run = cpu_clk_en && !state_retain;
  // Ports alone cannot tell halt from a stop wait, so track it
  always_ff @(posedge ref_clk) begin
    if (sys_rst || irq_pending) halted <= 1'b0;
    else if (run && halt_exec && !stop_exec) halted <= 1'b1;
  end
  a_halt_gates_clk: assert property (run && halt_exec && !stop_exec |=>
    !cpu_clk_en && state_retain && main_osc_en == $past(main_osc_en)) else $error("halt gate");
  a_stop_halts_osc: assert property (run && stop_exec |=>
    !main_osc_en && !cpu_clk_en && internal_ring_oscillator_en) else $error("stop osc");
  a_ring_stays_on: assert property (internal_ring_oscillator_en) else $error("ring off");
  a_retain_when_gated: assert property (!cpu_clk_en |-> state_retain) else $error("retain");
  a_halt_release_now: assert property (halted && irq_pending |=> cpu_clk_en)
    else $error("halt release");
  a_stop_wait_min: assert property ($rose(main_osc_en) && !cpu_clk_en |=>
    !cpu_clk_en [*8]) else $error("wait short");
  a_stop_wait_max: assert property ($rose(main_osc_en) && !cpu_clk_en |->
    ##[1:600] cpu_clk_en) else $error("wait long");
  a_progress_in_order: assert property (reg_req.rd && reg_req.addr == SOS_PROGRESS_ADDR |=>
    reg_rdata inside {8'h00, 8'h10, 8'h18, 8'h1C, 8'h1E, 8'h1F}) else $error("progress shape");
endmodule : sos_standby_ctrl_sva

bind sos_standby_ctrl sos_standby_ctrl_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .halt_exec(halt_exec), .stop_exec(stop_exec), .irq_pending(irq_pending), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en), .main_osc_en(main_osc_en),
  .internal_ring_oscillator_en(internal_ring_oscillator_en), .state_retain(state_retain));

/* File: sos_osc_model.sv */
`timescale 1ns/10ps
module sos_osc_model #(
  parameter int START = 6
) (
  // Clock
  input wire logic ref_clk,
  // Enables from the block
  input wire logic main_osc_en,
  input wire logic internal_ring_oscillator_en,
  // Oscillator status
  output logic main_osc_running = 1'b0,
  output logic ring_clock_tick = 1'b0
);
  int cnt = 0;
  // Crystal takes START cycles to start; that gap must not be counted
  always @(posedge ref_clk) begin
    cnt = main_osc_en ? (cnt < START ? cnt + 1 : cnt) : 0;
    main_osc_running <= main_osc_en && cnt >= START;
  end
  // Ring clock, unrelated in phase to ref_clk; flat when disabled
  always #27 ring_clock_tick = internal_ring_oscillator_en ? !ring_clock_tick : 1'b0;
endmodule : sos_osc_model

/* File: sos_standby_ctrl_bench.sv */
`timescale 1ns/10ps
module sos_standby_ctrl_bench import sos_pkg::*; ;
  logic ref_clk = 0, sys_rst = 1, halt_exec = 0, stop_exec = 0, irq_pending = 0;
  logic main_osc_halt_bit = 0, cpu_clock_source_bit = 0, internal_ring_oscillator_halt_bit = 0;
  logic main_osc_running, ring_clock_tick, cpu_clk_en, main_osc_en, internal_ring_oscillator_en, state_retain;
  logic [7:0] reg_rdata, rd_val, lfsr = 8'h57;
  logic [2:0] sel;
  sos_reg_req_t reg_req = '0;
  int failures = 0, tests_run = 0, cyc;
  // Short thresholds keep the run brief
  sos_standby_ctrl #(.THR_2P11(8), .THR_2P13(16), .THR_2P14(32), .THR_2P15(64),
    .THR_2P16(128)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .halt_exec(halt_exec),
    .stop_exec(stop_exec), .irq_pending(irq_pending), .main_osc_halt_bit(main_osc_halt_bit),
    .cpu_clock_source_bit(cpu_clock_source_bit), .internal_ring_oscillator_halt_bit(internal_ring_oscillator_halt_bit),
    .main_osc_running(main_osc_running), .ring_clock_tick(ring_clock_tick),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .cpu_clk_en(cpu_clk_en),
    .main_osc_en(main_osc_en), .internal_ring_oscillator_en(internal_ring_oscillator_en), .state_retain(state_retain));
  sos_osc_model model (.ref_clk(ref_clk), .main_osc_en(main_osc_en),
    .internal_ring_oscillator_en(internal_ring_oscillator_en), .main_osc_running(main_osc_running),
    .ring_clock_tick(ring_clock_tick));
  // 50 MHz clock
  always #10 ref_clk = !ref_clk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick();
    @(posedge ref_clk);
    #2;
  endtask : tick
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One byte access, strobe held for one edge
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    reg_req = '{addr: a, rd: !w, wr: w, wdata: d};
    tick();
    reg_req = '0;
    tick();
    rd_val = reg_rdata;
  endtask : bus
  task automatic pulse(input logic s);
    if (s) stop_exec = 1;
    else halt_exec = 1;
    tick();
    stop_exec = 0;
    halt_exec = 0;
  endtask : pulse
  // Bounded wait for the CPU clock to come back
  task automatic wait_run(input int lim);
    cyc = 0;
    while (cpu_clk_en !== 1'b1 && cyc < lim) begin
      tick();
      cyc++;
    end
    if (cyc >= lim) begin
      failures++;
      report_and_stop();
    end
  endtask : wait_run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  function automatic logic [7:0] exp_prog(input logic [2:0] s);
    return (s >= 1 && s <= 4) ? 8'h1F << (5 - s) & 8'h1F : 8'h1F;
  endfunction : exp_prog
  function automatic int thr(input logic [2:0] s);
    return (s >= 1 && s <= 4) ? 4 << s : 128;
  endfunction : thr
  function automatic logic [7:0] next_lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_lfsr
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    #2 sys_rst = 0;
    bus(SOS_PROGRESS_ADDR, 1, 8'hFF);
    bus(SOS_PROGRESS_ADDR, 0, 0);
    chk("progress", rd_val, 8'h00);
    bus(16'h0010, 0, 0);
    chk("unmapped", rd_val, 8'h00);
    // Halt keeps the oscillator, ignores stop, leaves on interrupt
    pulse(0);
    chk("halt", {6'h0, cpu_clk_en, main_osc_en}, 8'h01);
    chk("halt retain", {7'h0, state_retain}, 8'h01);
    pulse(1);
    chk("stop in halt", {7'h0, main_osc_en}, 8'h01);
    irq_pending = 1;
    tick();
    irq_pending = 0;
    chk("halt exit", {7'h0, cpu_clk_en}, 8'h01);
    chk("halt exit retain", {7'h0, state_retain}, 8'h00);
    // Peripherals and converter are idle in this bench before any standby entry
    // Select codes 1 to 5, then random codes 1 to 5 and clock sources
    for (int i = 0; i < 8; i++) begin
      lfsr = next_lfsr(lfsr);
      sel = (i < 5) ? 3'(i + 1) : 3'(lfsr % 5 + 1);
      internal_ring_oscillator_halt_bit = lfsr[0];
      bus(SOS_SELECT_ADDR, 1, {5'h0, sel});
      // Stop is only entered from main or ring clock; wait covers the polled bit
      cpu_clock_source_bit = (i >= 5) && lfsr[6];
      tick();
      bus(SOS_PROGRESS_ADDR, 0, 0);
      if (cpu_clock_source_bit) chk("src clear", rd_val, 8'h00);
      pulse(1);
      bus(SOS_PROGRESS_ADDR, 0, 0);
      chk("stop clear", rd_val, 8'h00);
      repeat (lfsr[2:0]) tick();
      irq_pending = 1;
      tick();
      irq_pending = 0;
      wait_run(700);
      if (!cpu_clock_source_bit) chk("wait", {7'h0, cyc >= thr(sel) + 6}, 8'h01);
      else chk("ring wait", {7'h0, cyc >= 2 * SOS_RING_WAIT_PERIODS}, 8'h01);
      chk("ring on", {7'h0, internal_ring_oscillator_en}, 8'h01);
      repeat (300) tick();
      bus(SOS_PROGRESS_ADDR, 0, 0);
      chk("progress", rd_val, exp_prog(sel));
      cpu_clock_source_bit = 0;
    end
    // Main halt bit clears progress and stops the crystal
    main_osc_halt_bit = 1;
    tick();
    bus(SOS_PROGRESS_ADDR, 0, 0);
    chk("halt bit", rd_val, 8'h00);
    chk("osc off", {7'h0, main_osc_en}, 8'h00);
    main_osc_halt_bit = 0;
    // Second reset brings back the select default
    sys_rst = 1;
    tick();
    tick();
    sys_rst = 0;
    bus(SOS_SELECT_ADDR, 0, 0);
    chk("select", rd_val, 8'h05);
    report_and_stop();
  end
endmodule : sos_standby_ctrl_bench
